/* File: design/char_seq_pkg.sv */
package char_seq_pkg;

	// Code geometry
	localparam int CODE_BITS = 5;
	localparam int CODE_COUNT = 32;

	// Shift combinations: all marking, and all but pulse three marking
	localparam logic [4:0] CODE_LETTERS = 5'h1F;
	localparam logic [4:0] CODE_FIGURES = 5'h1B;
	// Function combinations (bit 0 is pulse one)
	localparam logic [4:0] CODE_CR = 5'h08;
	localparam logic [4:0] CODE_LF = 5'h02;
	localparam logic [4:0] CODE_SPACE = 5'h04;
	localparam logic [4:0] CODE_BLANK = 5'h00;

	// Shaft timing
	localparam int CLK_HZ = 100_000_000;
	localparam int REV_CYCLES_DEF = 300;
	localparam int THIRD_CYCLES_DEF = REV_CYCLES_DEF / 3;
	// Line receive timing: one unit interval in clocks, sample at its middle
	localparam int UNIT_CYCLES_DEF = 64;

	// Reset values
	localparam logic RESET_FIGURES = 1'b0;
	localparam logic [6:0] RESET_COLUMN = 7'h00;
	localparam int LINE_LENGTH_DEF = 72;

	// Stage sequencing
	typedef enum {
		ST_IDLE,
		ST_CODE_BAR,
		ST_FUNCTION,
		ST_TYPE_BOX,
		ST_SPACING,
		ST_LINE_FEED
	} stage_t;

	// Function decode of one pattern; the case input figs is not decoded
	function automatic logic is_function(input logic [4:0] code, input logic figs);
		is_function = (code == CODE_LETTERS) || (code == CODE_FIGURES) ||
			(code == CODE_CR) || (code == CODE_LF) || (code == CODE_BLANK);
	endfunction

endpackage

/* File: design/shaft_stage.sv */
`timescale 1ns/1ps
// One clutch-driven stage: triggered from rest, runs a fixed count, returns to rest
module shaft_stage import char_seq_pkg::*; #(
	parameter int CYCLES = 300
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic trip_in,
	output logic busy_out,
	output logic done_out
);
	logic [$clog2(CYCLES+1)-1:0] cnt_r;
	logic busy_r;
	logic done_r;
	wire last_w = busy_r && (cnt_r == ($clog2(CYCLES+1))'(CYCLES - 1));

	// Trips while running are ignored, as a turning clutch cannot be retripped
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			busy_r <= 1'b0;
			cnt_r <= '0;
			done_r <= 1'b0;
		end else begin
			done_r <= last_w;
			if (last_w) begin
				busy_r <= 1'b0;
				cnt_r <= '0;
			end else if (busy_r) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (trip_in) begin
				busy_r <= 1'b1;
			end
		end
	end

	assign busy_out = busy_r;
	assign done_out = done_r;

	// Busy stands for exactly CYCLES clocks: high on the last one, low on the next
	a_stage_length: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		$rose(busy_r) |-> ##(CYCLES - 1) busy_r ##1 !busy_r)
		else $error("stage did not run its fixed length");
endmodule

/* File: design/skid_buffer.sv */
`timescale 1ns/1ps
// Two-entry buffer; a stall downstream loses no word
module skid_buffer import char_seq_pkg::*; #(
	parameter int WIDTH = 8
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	logic [WIDTH-1:0] mem_r [2];
	logic wp_r;
	logic rp_r;
	logic [1:0] cnt_r;
	wire push_w = in_valid_in && (cnt_r != 2'h2);
	wire pop_w = out_ready_in && (cnt_r != 2'h0);

	// Pointers and occupancy
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wp_r <= 1'b0;
			rp_r <= 1'b0;
			cnt_r <= 2'h0;
		end else begin
			if (push_w) wp_r <= ~wp_r;
			if (pop_w) rp_r <= ~rp_r;
			cnt_r <= cnt_r + {1'b0, push_w} - {1'b0, pop_w};
		end
	end

	// Storage needs no reset
	always_ff @(posedge sys_clk_in) begin
		if (push_w) mem_r[wp_r] <= in_data_in;
	end

	assign in_ready_out = (cnt_r != 2'h2);
	assign out_valid_out = (cnt_r != 2'h0);
	assign out_data_out = mem_r[rp_r];
endmodule

/* File: design/char_sequencer.sv */
`timescale 1ns/1ps
module char_sequencer import char_seq_pkg::*; #(
	parameter int REV_CYCLES = REV_CYCLES_DEF,
	parameter int THIRD_CYCLES = THIRD_CYCLES_DEF,
	parameter int UNIT_CYCLES = UNIT_CYCLES_DEF,
	parameter int LINE_LENGTH = LINE_LENGTH_DEF
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic line_in,
	input wire logic double_feed_in,
	output logic figures_out,
	output logic [4:0] code_bars_out,
	output logic func_cr_out,
	output logic func_lf_out,
	output logic [5:0] pallet_out,
	output logic strike_out,
	output logic ribbon_step_out,
	output logic space_step_out,
	output logic line_step_out,
	output logic [6:0] column_out,
	output logic char_valid_out,
	input wire logic char_ready_in,
	output logic [5:0] char_data_out
);
	// Line and feed-setting synchronisers: only the second stage is read by logic
	logic line_s1_r;
	logic line_s2_r;
	logic dbl_s1_r;
	logic dbl_s2_r;
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			line_s1_r <= 1'b1;
			line_s2_r <= 1'b1;
			dbl_s1_r <= 1'b0;
			dbl_s2_r <= 1'b0;
		end else begin
			line_s1_r <= line_in;
			line_s2_r <= line_s1_r;
			dbl_s1_r <= double_feed_in;
			dbl_s2_r <= dbl_s1_r;
		end
	end

	// Selector: one revolution from the start pulse, samples five pulses mid-unit
	logic sel_busy;
	logic sel_done;
	logic [4:0] latch_r;
	logic [2:0] bit_idx_r;
	logic [15:0] unit_cnt_r;
	logic selected_r;
	wire sel_trip_w = !sel_busy && !line_s2_r;
	wire sample_w = sel_busy && (unit_cnt_r == 16'((UNIT_CYCLES * 3) / 2 - 1)) &&
		(bit_idx_r < 3'h5);

	shaft_stage #(.CYCLES(REV_CYCLES)) u_selector (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.trip_in(sel_trip_w),
		.busy_out(sel_busy),
		.done_out(sel_done)
	);

	// Pulse sampling; first sample 1.5 units after the start edge, then each unit
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			latch_r <= 5'h00;
			bit_idx_r <= 3'h0;
			unit_cnt_r <= 16'h0000;
			selected_r <= 1'b0;
		end else if (!sel_busy) begin
			bit_idx_r <= 3'h0;
			unit_cnt_r <= 16'h0000;
			selected_r <= 1'b0;
		end else if (sample_w) begin
			latch_r[bit_idx_r] <= line_s2_r;
			bit_idx_r <= bit_idx_r + 3'h1;
			unit_cnt_r <= 16'((UNIT_CYCLES * 3) / 2 - 1 - UNIT_CYCLES);
			selected_r <= (bit_idx_r == 3'h4);
		end else begin
			unit_cnt_r <= unit_cnt_r + 16'h0001;
			selected_r <= 1'b0;
		end
	end

	// Hold a finished selection until the code bar stage can take it
	logic pend_cb_r;
	logic cb_busy;
	logic cb_done;
	wire cb_start_w = pend_cb_r && !cb_busy;
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) pend_cb_r <= 1'b0;
		else if (selected_r) pend_cb_r <= 1'b1;
		else if (cb_start_w) pend_cb_r <= 1'b0;
	end

	// Code bar stage
	shaft_stage #(.CYCLES(REV_CYCLES)) u_code_bar (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.trip_in(cb_start_w),
		.busy_out(cb_busy),
		.done_out(cb_done)
	);

	// Code bars: marking sets a bar, spacing clears it
	logic [4:0] bars_r;
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) bars_r <= 5'h00;
		else if (cb_start_w) bars_r <= latch_r;
	end

	// Function and type box both tripped by code bar completion
	logic fn_busy;
	logic fn_done;
	logic tb_busy;
	logic tb_done;
	shaft_stage #(.CYCLES(REV_CYCLES)) u_function (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.trip_in(cb_done),
		.busy_out(fn_busy),
		.done_out(fn_done)
	);

	// Case state and print column are read by the decode below
	logic figures_r;
	logic [6:0] column_r;

	// Function decode
	wire is_letters_w = (bars_r == CODE_LETTERS);
	wire is_figures_w = (bars_r == CODE_FIGURES);
	wire is_func_w = is_function(bars_r, figures_r);
	wire is_graphic_w = !is_func_w && (bars_r != CODE_SPACE);
	wire at_eol_w = (column_r >= 7'(LINE_LENGTH - 1));
	wire suppress_w = is_func_w || at_eol_w;

	// Case state; letters after reset
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) figures_r <= RESET_FIGURES;
		else if (cb_done && is_letters_w) figures_r <= 1'b0;
		else if (cb_done && is_figures_w) figures_r <= 1'b1;
	end

	// Function outputs: set at trip, stripped at end of the function revolution
	logic cr_r;
	logic lf_r;
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cr_r <= 1'b0;
			lf_r <= 1'b0;
		end else if (cb_done) begin
			cr_r <= (bars_r == CODE_CR);
			lf_r <= (bars_r == CODE_LF);
		end else if (fn_done) begin
			cr_r <= 1'b0;
			lf_r <= 1'b0;
		end
	end

	// Type box: one revolution, strike at mid revolution
	shaft_stage #(.CYCLES(REV_CYCLES)) u_type_box (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.trip_in(cb_done),
		.busy_out(tb_busy),
		.done_out(tb_done)
	);
	logic [5:0] pallet_r;
	logic strike_r;
	logic [$clog2(REV_CYCLES+1)-1:0] tb_cnt_r;
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pallet_r <= 6'h00;
			strike_r <= 1'b0;
			tb_cnt_r <= '0;
		end else begin
			tb_cnt_r <= tb_busy ? tb_cnt_r + 1'b1 : '0;
			strike_r <= tb_busy && (tb_cnt_r == ($clog2(REV_CYCLES+1))'(REV_CYCLES / 2));
			if (cb_done) pallet_r <= is_func_w ? {1'b0, CODE_BLANK} : {figures_r, bars_r};
		end
	end
	// Spacing: tripped at type box end unless suppressed
	logic sp_busy;
	logic sp_done;
	logic sp_req_r;
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) sp_req_r <= 1'b0;
		else if (cb_done) sp_req_r <= !suppress_w;
	end
	wire sp_trip_w = tb_done && sp_req_r;
	shaft_stage #(.CYCLES(THIRD_CYCLES)) u_spacing (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.trip_in(sp_trip_w),
		.busy_out(sp_busy),
		.done_out(sp_done)
	);

	// Line feed: tripped at function end for line feed code, one or two thirds
	// The latched decode is used, as the code bars may already hold the next character
	logic lf_busy;
	logic lf_done;
	logic lf_pend_r;
	logic lf_left_r;
	logic lf_step_r;
	wire lf_trip_w = (fn_done && lf_r) || lf_left_r;
	shaft_stage #(.CYCLES(THIRD_CYCLES)) u_line_feed (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.trip_in(lf_trip_w && !lf_busy),
		.busy_out(lf_busy),
		.done_out(lf_done)
	);
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lf_pend_r <= 1'b0;
			lf_left_r <= 1'b0;
			lf_step_r <= 1'b0;
		end else begin
			lf_step_r <= lf_done;
			if (fn_done && lf_r) lf_pend_r <= dbl_s2_r;
			else if (lf_done && lf_pend_r) begin
				lf_pend_r <= 1'b0;
				lf_left_r <= 1'b1;
			end else if (lf_left_r && !lf_busy) lf_left_r <= 1'b0;
		end
	end

	// Print column: carriage return wins over a spacing step
	logic space_step_r;
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			column_r <= RESET_COLUMN;
			space_step_r <= 1'b0;
		end else begin
			space_step_r <= sp_done;
			if (cb_done && (bars_r == CODE_CR)) column_r <= RESET_COLUMN;
			else if (sp_done) column_r <= column_r + 7'h01;
		end
	end

	// Graphic characters go out through the two-entry buffer; with a stalled sink, any arriving while two are held are dropped
	skid_buffer #(.WIDTH(6)) u_out_buf (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.in_valid_in(cb_done && is_graphic_w),
		.in_ready_out(),
		.in_data_in({figures_r, bars_r}),
		.out_valid_out(char_valid_out),
		.out_ready_in(char_ready_in),
		.out_data_out(char_data_out)
	);

	assign figures_out = figures_r;
	assign code_bars_out = bars_r;
	assign func_cr_out = cr_r;
	assign func_lf_out = lf_r;
	assign pallet_out = pallet_r;
	assign strike_out = strike_r;
	assign ribbon_step_out = strike_r;
	assign space_step_out = space_step_r;
	assign line_step_out = lf_step_r;
	assign column_out = column_r;

	a_order_cb_fn: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		cb_done |=> fn_busy && tb_busy)
		else $error("function and type box not tripped after code bars");
	a_spacing_suppress: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(tb_done && !sp_req_r) |=> !sp_busy)
		else $error("spacing ran while suppressed");
	a_column_step: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(sp_done && !(cb_done && bars_r == CODE_CR)) |=> column_r == $past(column_r) + 7'h01)
		else $error("column did not advance by one");
	a_func_once: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		fn_done && !cb_done |=> !cr_r && !lf_r)
		else $error("function output not cleared");
	a_shift_letters: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(cb_done && is_letters_w) |=> !figures_r)
		else $error("letters code did not select letters");
	a_shift_figures: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(cb_done && is_figures_w) |=> figures_r)
		else $error("figures code did not select figures");
	a_blank_pallet: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(cb_done && is_func_w) |=> pallet_r == 6'h00)
		else $error("function did not select blank pallet");
	a_cb_after_sel: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		selected_r && !cb_busy |=> ##1 cb_busy)
		else $error("code bar stage not tripped after selection");
endmodule

/* File: sim/line_tx_model.sv */
`timescale 1ns/1ps
// Remote start-stop sender; the line rests marking between characters
module line_tx_model #(
	parameter int UNIT = 50,
	parameter int STOP = 71
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic send_in,
	input wire logic [4:0] code_in,
	input wire logic short_stop_in,
	output logic line_out,
	output logic busy_out
);
	logic [9:0] cnt_r;
	logic [2:0] pos_r;
	logic [4:0] code_r;
	logic [9:0] stop_r;

	// Start spacing, five pulses first-to-last, stop marking
	always @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			busy_out <= 1'b0;
			line_out <= 1'b1;
			cnt_r <= '0;
			pos_r <= '0;
			code_r <= '0;
			stop_r <= '0;
		end else if (!busy_out) begin
			if (send_in) begin
				busy_out <= 1'b1;
				line_out <= 1'b0;
				pos_r <= '0;
				cnt_r <= 10'(UNIT - 1);
				code_r <= code_in;
				stop_r <= short_stop_in ? 10'(UNIT) : 10'(STOP);
			end
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - 10'h001;
		end else if (pos_r < 3'h5) begin
			line_out <= code_r[pos_r];
			pos_r <= pos_r + 3'h1;
			cnt_r <= 10'(UNIT - 1);
		end else if (pos_r == 3'h5) begin
			line_out <= 1'b1;
			pos_r <= 3'h6;
			cnt_r <= stop_r - 10'h001;
		end else begin
			busy_out <= 1'b0;
		end
	end
endmodule

/* File: sim/test_printer_character_sequencer.sv */
`timescale 1ns/1ps
module test_printer_character_sequencer import char_seq_pkg::*;;
	localparam int REV = 300;
	localparam int THIRD = 100;
	localparam int UNIT = 50;
	localparam int LINE_LEN = 4;
	// Every stage of one character has run to rest after this many cycles
	localparam int SETTLE = 4 * REV + 3 * THIRD;

	logic sys_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic double_feed_in = 1'b0;
	logic char_ready_in = 1'b1;
	logic send = 1'b0;
	logic [4:0] send_code = 5'h00;
	logic short_stop = 1'b0;
	logic line, tx_busy, figures_out, func_cr_out, func_lf_out;
	logic strike_out, ribbon_step_out, space_step_out, line_step_out, char_valid_out;
	logic [4:0] code_bars_out;
	logic [5:0] pallet_out, char_data_out;
	logic [6:0] column_out;
	logic cr_q, lf_q;
	int strikes = 0, ribbons = 0, spaces = 0, lines = 0, crs = 0, lfs = 0;
	logic [5:0] got_q[$];
	int fails = 0;
	int tests_run = 0;

	always #5 sys_clk_in = ~sys_clk_in;

	line_tx_model #(.UNIT(UNIT), .STOP(71)) partner (.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in), .send_in(send), .code_in(send_code),
		.short_stop_in(short_stop), .line_out(line), .busy_out(tx_busy));

	char_sequencer #(.REV_CYCLES(REV), .THIRD_CYCLES(THIRD), .UNIT_CYCLES(UNIT),
		.LINE_LENGTH(LINE_LEN)) DUT (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
		.line_in(line), .double_feed_in(double_feed_in), .figures_out(figures_out),
		.code_bars_out(code_bars_out), .func_cr_out(func_cr_out),
		.func_lf_out(func_lf_out), .pallet_out(pallet_out), .strike_out(strike_out),
		.ribbon_step_out(ribbon_step_out), .space_step_out(space_step_out),
		.line_step_out(line_step_out), .column_out(column_out),
		.char_valid_out(char_valid_out), .char_ready_in(char_ready_in),
		.char_data_out(char_data_out));

	// Count pulses and function onsets, and collect the graphic stream
	always @(posedge sys_clk_in) begin
		cr_q <= func_cr_out;
		lf_q <= func_lf_out;
		if (strike_out === 1'b1) strikes++;
		if (ribbon_step_out === 1'b1) ribbons++;
		if (space_step_out === 1'b1) spaces++;
		if (line_step_out === 1'b1) lines++;
		if (func_cr_out === 1'b1 && cr_q === 1'b0) crs++;
		if (func_lf_out === 1'b1 && lf_q === 1'b0) lfs++;
		if (char_valid_out === 1'b1 && char_ready_in === 1'b1) got_q.push_back(char_data_out);
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One character from the far end, then wait until every stage rests
	task automatic send_char(input logic [4:0] c, input logic shrt);
		@(posedge sys_clk_in);
		send <= 1'b1;
		send_code <= c;
		short_stop <= shrt;
		@(posedge sys_clk_in);
		send <= 1'b0;
		// The sender's busy flag shows only one edge after it took the request
		@(posedge sys_clk_in);
		for (int i = 0; i < 1000 && tx_busy !== 1'b0; i++) @(posedge sys_clk_in);
		if (tx_busy !== 1'b0) begin
			fails++;
			$display("MISMATCH at %0t: sender never finished", $time);
		end
		repeat (SETTLE) @(posedge sys_clk_in);
	endtask

	task automatic test_reset();
		check(8'(figures_out), 8'h00);
		check(8'(column_out), 8'h00);
		$display("test_reset done");
	endtask

	task automatic test_graphic();
		int s0 = strikes, p0 = spaces, r0 = ribbons, n0 = got_q.size();
		send_char(5'h03, 1'b0);
		check(8'(code_bars_out), 8'h03);
		check(8'(pallet_out), 8'h03);
		check(8'(strikes - s0), 8'h01);
		check(8'(ribbons - r0), 8'h01);
		check(8'(spaces - p0), 8'h01);
		check(8'(column_out), 8'h01);
		check(8'(got_q.size() - n0), 8'h01);
		check(8'(got_q[$]), 8'h03);
		// A space moves the carriage but hands no character out
		send_char(CODE_SPACE, 1'b0);
		check(8'(column_out), 8'h02);
		check(8'(got_q.size() - n0), 8'h01);
		$display("test_graphic done");
	endtask

	task automatic test_shift();
		int p0 = spaces;
		send_char(CODE_FIGURES, 1'b1);
		check(8'(figures_out), 8'h01);
		check(8'(spaces - p0), 8'h00);
		send_char(5'h03, 1'b1);
		check(8'(got_q[$]), 8'h23);
		send_char(CODE_LETTERS, 1'b0);
		check(8'(figures_out), 8'h00);
		check(8'(column_out), 8'h03);
		$display("test_shift done");
	endtask

	task automatic test_cr();
		int c0 = crs, n0 = got_q.size();
		send_char(CODE_CR, 1'b0);
		check(8'(crs - c0), 8'h01);
		check(8'(func_cr_out), 8'h00);
		check(8'(column_out), 8'h00);
		check(8'(pallet_out), 8'h00);
		check(8'(got_q.size() - n0), 8'h00);
		$display("test_cr done");
	endtask

	task automatic test_lf();
		int l0 = lines, f0 = lfs;
		send_char(CODE_LF, 1'b0);
		check(8'(lines - l0), 8'h01);
		check(8'(lfs - f0), 8'h01);
		double_feed_in <= 1'b1;
		send_char(CODE_LF, 1'b1);
		check(8'(lines - l0), 8'h03);
		check(8'(column_out), 8'h00);
		double_feed_in <= 1'b0;
		$display("test_lf done");
	endtask

	// Receiver stalls for two words; none may be lost or reordered
	task automatic test_stall();
		int n0 = got_q.size();
		char_ready_in <= 1'b0;
		send_char(5'h05, 1'b0);
		send_char(5'h06, 1'b0);
		check(8'(char_valid_out), 8'h01);
		check(8'(got_q.size() - n0), 8'h00);
		char_ready_in <= 1'b1;
		repeat (4) @(posedge sys_clk_in);
		check(8'(got_q.size() - n0), 8'h02);
		check(8'(got_q[n0]), 8'h05);
		check(8'(got_q[n0 + 1]), 8'h06);
		check(8'(char_valid_out), 8'h00);
		$display("test_stall done");
	endtask

	task automatic test_eol();
		logic [6:0] prev;
		for (int i = 0; i < 4; i++) send_char(5'h07, 1'b0);
		prev = column_out;
		check(8'(prev), 8'(LINE_LEN - 1));
		send_char(5'h07, 1'b0);
		check(8'(column_out), 8'(prev));
		check(8'(column_out <= 7'(LINE_LEN)), 8'h01);
		$display("test_eol done");
	endtask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (40 * SETTLE) @(posedge sys_clk_in);
		fails++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		complete_run();
	end

	initial begin
		repeat (4) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		repeat (2) @(posedge sys_clk_in);
		test_reset();
		test_graphic();
		test_shift();
		test_cr();
		test_lf();
		test_stall();
		test_eol();
		complete_run();
	end
endmodule
